/* File: rfs_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module rfs_status_regs (
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Register port
  input  wire logic       bus_rd,
  input  wire logic       bus_wr,
  input  wire logic       bus_space_b,
  input  wire logic [5:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  output logic      [7:0] bus_rdata,
  // Receiver gain sources, same clock
  input  wire logic [3:0] am_gain_cut_setting,
  input  wire logic [3:0] pm_gain_cut_setting,
  input  wire logic [3:0] am_squelch_cut,
  input  wire logic [3:0] pm_squelch_cut,
  input  wire logic [3:0] am_agc_cut,
  input  wire logic [3:0] pm_agc_cut,
  // Live status, same clock
  input  wire logic       rx_channel_pm,
  input  wire logic       tx_active,
  input  wire logic       tx_ca_auto,
  input  wire logic       rx_enabled,
  input  wire logic       rx_receiving,
  input  wire logic       efd_peer_mode,
  input  wire logic       collision_avoid_armed,
  // Live status from analog pins
  input  wire logic       ext_field_pin,
  input  wire logic       osc_running_pin,
  input  wire logic       osc_stable_pin,
  input  wire logic       cal_done_pin,
  input  wire logic       cal_fail_pin,
  input  wire logic [4:0] cal_value_pin,
  // Capacitive sensor controls
  output logic      [4:0] cap_cal_in_use,
  output logic            cap_auto_cal_en,
  output logic      [2:0] cap_gain_code,
  output logic            cap_gain_valid,
  // Overshoot protection
  input  wire logic [3:0] overshoot_step,
  output logic      [1:0] overshoot_drive_level,
  output logic     [13:0] overshoot_bit_pattern,
  output logic            overshoot_apply,
  output logic            drive_from_dr,
  output logic            drive_from_am,
  output logic            drive_stop
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************

  rfs_pkg::rfs_live_s live_pin;
  rfs_pkg::rfs_live_s live_s;

  // Calibration value crosses in the same bundle as done and is not gated by done
  always_comb begin
    live_pin.ext_field   = ext_field_pin;
    live_pin.osc_running = osc_running_pin;
    live_pin.osc_stable  = osc_stable_pin;
    live_pin.cal_done    = cal_done_pin;
    live_pin.cal_fail    = cal_fail_pin;
    live_pin.cal_value   = cal_value_pin;
  end

  rfs_sync2 #(
    .W(rfs_pkg::LIVE_W)
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (live_pin),
    .sync_out (live_s)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Saturating sum of three reductions; a plain add would wrap past 15
  function automatic logic [3:0] gain_sum(
    input logic [3:0] a,
    input logic [3:0] b,
    input logic [3:0] c
  );
    logic [5:0] s;
    s = {2'b00, a} + {2'b00, b} + {2'b00, c};
    if (s > {2'b00, rfs_pkg::GAIN_MAX}) begin
      gain_sum = rfs_pkg::GAIN_MAX;
    end else begin
      gain_sum = s[3:0];
    end
  endfunction

  // ****************************************************************
  // Decode of stored fields
  // ****************************************************************

  rfs_pkg::rfs_state_s state_r;
  rfs_pkg::rfs_state_s state_nxt;
  logic [4:0]          mcal;
  logic [13:0]         pattern;
  logic                wr_cap_ctrl;
  logic                wr_ov_high;
  logic                wr_ov_low;

  // Manual value, weights 1.6/0.8/0.4/0.2/0.1 pF from top bit down
  assign mcal = state_r.cap_ctrl[rfs_pkg::CAP_MCAL_LSB +: rfs_pkg::CAP_MCAL_W];

  // High register holds bits 13..8, low register bits 7..0
  assign pattern = {state_r.ov_high[rfs_pkg::OV_HIGH_W-1:0], state_r.ov_low};

  // Only the writable registers have write enables; nothing else moves
  assign wr_cap_ctrl = bus_wr && !bus_space_b && (bus_addr == rfs_pkg::OFF_CAP_CTRL);
  assign wr_ov_high  = bus_wr && bus_space_b && (bus_addr == rfs_pkg::OFF_OV_HIGH);
  assign wr_ov_low   = bus_wr && bus_space_b && (bus_addr == rfs_pkg::OFF_OV_LOW);

  // ****************************************************************
  // Next state
  // ****************************************************************

  always_comb begin
    state_nxt = state_r;

    // Writable configuration; writes elsewhere fall through untouched
    if (wr_cap_ctrl) begin
      state_nxt.cap_ctrl = bus_wdata;
    end
    if (wr_ov_high) begin
      state_nxt.ov_high = bus_wdata;
    end
    if (wr_ov_low) begin
      state_nxt.ov_low = bus_wdata;
    end

    // Total gain reduction per channel
    state_nxt.gain_cut[7:4] = gain_sum(am_gain_cut_setting, am_squelch_cut,
                                       am_agc_cut);
    state_nxt.gain_cut[3:0] = gain_sum(pm_gain_cut_setting, pm_squelch_cut,
                                       pm_agc_cut);

    // Calibration display: manual value counts as ended, never failed
    if (mcal == rfs_pkg::MCAL_AUTO) begin
      state_nxt.cap_disp[7:3] = live_s.cal_value;
      state_nxt.cap_disp[rfs_pkg::DISP_END_BIT] = live_s.cal_done;
      state_nxt.cap_disp[rfs_pkg::DISP_ERR_BIT] = live_s.cal_fail;
    end else begin
      state_nxt.cap_disp[7:3] = mcal;
      state_nxt.cap_disp[rfs_pkg::DISP_END_BIT] = 1'b1;
      state_nxt.cap_disp[rfs_pkg::DISP_ERR_BIT] = 1'b0;
    end
    state_nxt.cap_disp[0] = 1'b0; // Reserved reads zero

    // Auxiliary status flags
    state_nxt.aux[rfs_pkg::AUX_CHA_BIT]   = rx_channel_pm;
    state_nxt.aux[rfs_pkg::AUX_EFD_BIT]   = live_s.ext_field;
    state_nxt.aux[rfs_pkg::AUX_TX_BIT]    = tx_active && !tx_ca_auto;
    state_nxt.aux[rfs_pkg::AUX_OSC_BIT]   = live_s.osc_running && live_s.osc_stable;
    state_nxt.aux[rfs_pkg::AUX_RXON_BIT]  = rx_enabled;
    state_nxt.aux[rfs_pkg::AUX_RXACT_BIT] = rx_receiving;
    state_nxt.aux[rfs_pkg::AUX_PEER_BIT]  = efd_peer_mode;
    state_nxt.aux[rfs_pkg::AUX_CA_BIT]    = collision_avoid_armed;

    // Pattern bit for the current shaping step; steps past 13 apply none
    if (overshoot_step < 4'(rfs_pkg::OV_PAT_W)) begin
      state_nxt.ov_apply = pattern[overshoot_step];
    end else begin
      state_nxt.ov_apply = 1'b0;
    end

    // Read data valid only in the cycle after the strobe
    state_nxt.rdata = rfs_pkg::RST_ZERO;
    if (bus_rd) begin
      if (!bus_space_b && bus_addr == rfs_pkg::OFF_GAIN_CUT) begin
        state_nxt.rdata = state_r.gain_cut;
      end else if (!bus_space_b && bus_addr == rfs_pkg::OFF_CAP_CTRL) begin
        state_nxt.rdata = state_r.cap_ctrl;
      end else if (!bus_space_b && bus_addr == rfs_pkg::OFF_CAP_DISP) begin
        state_nxt.rdata = state_r.cap_disp;
      end else if (!bus_space_b && bus_addr == rfs_pkg::OFF_AUX) begin
        state_nxt.rdata = state_r.aux;
      end else if (bus_space_b && bus_addr == rfs_pkg::OFF_OV_HIGH) begin
        state_nxt.rdata = state_r.ov_high;
      end else if (bus_space_b && bus_addr == rfs_pkg::OFF_OV_LOW) begin
        state_nxt.rdata = state_r.ov_low;
      end else begin
        state_nxt.rdata = rfs_pkg::RST_ZERO; // Unmapped reads zero
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Configuration and status all clear together
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= rfs_pkg::STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Calibration value handed to the sensor; auto flag while field is zero
  assign cap_cal_in_use  = state_r.cap_disp[7:3];
  assign cap_auto_cal_en = (mcal == rfs_pkg::MCAL_AUTO);
  assign cap_gain_code   = state_r.cap_ctrl[rfs_pkg::CAP_GAIN_LSB +: rfs_pkg::CAP_GAIN_W];

  // Unused gain codes are flagged so the sensor can hold its last gain
  always_comb begin
    case (cap_gain_code)
      rfs_pkg::RFS_GAIN_2P8,
      rfs_pkg::RFS_GAIN_6P5,
      rfs_pkg::RFS_GAIN_1P1,
      rfs_pkg::RFS_GAIN_0P5,
      rfs_pkg::RFS_GAIN_0P35: cap_gain_valid = 1'b1;
      default:                cap_gain_valid = 1'b0;
    endcase
  end

  assign overshoot_drive_level = state_r.ov_high[7:rfs_pkg::OV_MODE_LSB];
  assign overshoot_bit_pattern = pattern;
  assign overshoot_apply       = state_r.ov_apply;

  // Reserved level drives nothing rather than guess a supply
  assign drive_from_dr = (overshoot_drive_level == rfs_pkg::RFS_DRIVE_DR);
  assign drive_from_am = (overshoot_drive_level == rfs_pkg::RFS_DRIVE_AM);
  assign drive_stop    = (overshoot_drive_level == rfs_pkg::RFS_DRIVE_STOP);

  assign bus_rdata = state_r.rdata;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Independent totals, so the gain checks do not reuse the design's helper
  logic [5:0] am_sum6;
  logic [5:0] pm_sum6;

  assign am_sum6 = {2'b00, am_gain_cut_setting} + {2'b00, am_squelch_cut}
                   + {2'b00, am_agc_cut};
  assign pm_sum6 = {2'b00, pm_gain_cut_setting} + {2'b00, pm_squelch_cut}
                   + {2'b00, pm_agc_cut};

  // Write then read back the sensor control register
  sequence s_ctrl_write;
    wr_cap_ctrl;
  endsequence

  sequence s_ctrl_read;
    bus_rd && !bus_space_b && bus_addr == rfs_pkg::OFF_CAP_CTRL;
  endsequence

  a_reset_zeroes: assert property (
    $rose(rst_b) |-> (state_r.cap_ctrl == 8'h00 && state_r.ov_high == 8'h00
                      && state_r.ov_low == 8'h00))
    else $error("config registers not zero after reset");

  a_ro_write_kept: assert property (
    (bus_wr && !bus_space_b && bus_addr == rfs_pkg::OFF_GAIN_CUT)
    |=> $stable(state_r.cap_ctrl) && $stable(state_r.ov_high) && $stable(state_r.ov_low))
    else $error("read-only write changed configuration");

  a_ctrl_readback: assert property (
    s_ctrl_write ##1 !bus_wr ##1 s_ctrl_read |=> bus_rdata == $past(bus_wdata, 3))
    else $error("control readback mismatch");

  a_gain_am_sum: assert property (
    1'b1 |=> state_r.gain_cut[7:4] == (($past(am_sum6) > 6'h0F) ? 4'hF
                                       : $past(am_sum6[3:0])))
    else $error("AM gain cut total wrong");

  a_gain_pm_sum: assert property (
    1'b1 |=> state_r.gain_cut[3:0] == (($past(pm_sum6) > 6'h0F) ? 4'hF
                                       : $past(pm_sum6[3:0])))
    else $error("PM gain cut total wrong");

  a_rx_flags: assert property (
    1'b1 |=> state_r.aux[3:0] == $past({rx_enabled, rx_receiving, efd_peer_mode,
                                        collision_avoid_armed}))
    else $error("receive and detector flags wrong");

  a_gain_code_ok: assert property (
    cap_gain_valid == (cap_gain_code inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h6}))
    else $error("sensor gain code validity wrong");

  a_auto_cal_used: assert property (
    (mcal == 5'h00) |=> ($past(mcal) != 5'h00) || cap_cal_in_use == $past(live_s.cal_value))
    else $error("automatic calibration value not shown");

  a_manual_cal_end: assert property (
    (mcal != 5'h00) ##1 ($past(mcal) == mcal)
    |-> state_r.cap_disp[2] && !state_r.cap_disp[1] && cap_cal_in_use == mcal)
    else $error("manual calibration display wrong");

  a_tx_ca_hidden: assert property (
    tx_ca_auto |=> !state_r.aux[5])
    else $error("collision avoidance send shown as transmission");

  a_osc_both: assert property (
    state_r.aux[4] |-> $past(live_s.osc_running) && $past(live_s.osc_stable))
    else $error("oscillator flag without stable clock");

  a_ext_field_lag: assert property (
    $rose(ext_field_pin) ##1 ext_field_pin[*3] |-> state_r.aux[6])
    else $error("external field flag missed");

  a_pattern_apply: assert property (
    (overshoot_step == 4'hD) |=> overshoot_apply == $past(state_r.ov_high[5]))
    else $error("pattern bit 13 not applied");

  a_drive_decode: assert property (
    $onehot0({drive_from_dr, drive_from_am, drive_stop})
    && ((overshoot_drive_level == 2'h3) == !(drive_from_dr || drive_from_am || drive_stop)))
    else $error("drive level decode wrong");

  a_read_one_cycle: assert property (
    !bus_rd |=> bus_rdata == 8'h00)
    else $error("read data outside its cycle");

endmodule
`default_nettype wire

/* File: rfs_pkg.sv */
// ****************************************************************
// Shared constants and types of the front end status/config bank
// ****************************************************************
package rfs_pkg;

  // Bus widths
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // Register offsets, space A
  localparam logic [5:0] OFF_GAIN_CUT = 6'h2E;
  localparam logic [5:0] OFF_CAP_CTRL = 6'h2F;
  localparam logic [5:0] OFF_CAP_DISP = 6'h30;
  localparam logic [5:0] OFF_AUX      = 6'h31;
  // Register offsets, space B
  localparam logic [5:0] OFF_OV_HIGH  = 6'h30;
  localparam logic [5:0] OFF_OV_LOW   = 6'h31;

  // Field positions
  localparam int GAIN_AM_LSB  = 4;
  localparam int CAP_MCAL_LSB = 3;
  localparam int CAP_MCAL_W   = 5;
  localparam int CAP_GAIN_LSB = 0;
  localparam int CAP_GAIN_W   = 3;
  localparam int DISP_END_BIT = 2;
  localparam int DISP_ERR_BIT = 1;
  localparam int OV_MODE_LSB  = 6;
  localparam int OV_HIGH_W    = 6;
  localparam int OV_PAT_W     = 14;
  localparam int AUX_CHA_BIT  = 7;
  localparam int AUX_EFD_BIT  = 6;
  localparam int AUX_TX_BIT   = 5;
  localparam int AUX_OSC_BIT  = 4;
  localparam int AUX_RXON_BIT = 3;
  localparam int AUX_RXACT_BIT = 2;
  localparam int AUX_PEER_BIT = 1;
  localparam int AUX_CA_BIT   = 0;

  // Reset values and limits
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [3:0] GAIN_MAX = 4'hF;
  localparam logic [4:0] MCAL_AUTO = 5'h00;

  // Capacitive sensor gain codes
  typedef enum logic [2:0] {
    RFS_GAIN_2P8  = 3'h0,
    RFS_GAIN_6P5  = 3'h1,
    RFS_GAIN_1P1  = 3'h2,
    RFS_GAIN_0P5  = 3'h4,
    RFS_GAIN_0P35 = 3'h6
  } rfs_cap_gain_e;

  // Overshoot drive level codes
  typedef enum logic [1:0] {
    RFS_DRIVE_DR   = 2'h0,
    RFS_DRIVE_AM   = 2'h1,
    RFS_DRIVE_STOP = 2'h2,
    RFS_DRIVE_RSVD = 2'h3
  } rfs_drive_e;

  // Asynchronous live inputs, carried together through the synchroniser
  typedef struct packed {
    logic       ext_field;
    logic       osc_running;
    logic       osc_stable;
    logic       cal_done;
    logic       cal_fail;
    logic [4:0] cal_value;
  } rfs_live_s;

  localparam int LIVE_W = 10;

  // Whole state of the register bank
  typedef struct packed {
    logic [7:0]  cap_ctrl;
    logic [7:0]  ov_high;
    logic [7:0]  ov_low;
    logic [7:0]  gain_cut;
    logic [7:0]  cap_disp;
    logic [7:0]  aux;
    logic [7:0]  rdata;
    logic        ov_apply;
  } rfs_state_s;

  localparam rfs_state_s STATE_RST = '{
    cap_ctrl: RST_ZERO, ov_high: RST_ZERO, ov_low: RST_ZERO,
    gain_cut: RST_ZERO, cap_disp: RST_ZERO, aux: RST_ZERO,
    rdata: RST_ZERO, ov_apply: 1'b0
  };

endpackage

/* File: rfs_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Two flip-flop synchroniser for a bundle of pin levels
// ****************************************************************
module rfs_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // Stage 0 feeds stage 1 only
  logic [1:0][W-1:0] state_r;
  logic [1:0][W-1:0] state_nxt;

  // Refuse an empty bundle at elaboration rather than build nothing
  if (W < 1) begin : g_bad_width
    $error("rfs_sync2 needs W of at least one");
  end

  // Shift one stage per clock
  always_comb begin
    state_nxt[0] = async_in;
    state_nxt[1] = state_r[0];
  end

  // Synchronous reset to zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sync_out = state_r[1];

endmodule
`default_nettype wire

/* File: rfs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host controller model on the register port
// ****************************************************************
module rfs_host_model (
  input  wire logic       clk,
  output logic            bus_rd,
  output logic            bus_wr,
  output logic            bus_space_b,
  output logic      [5:0] bus_addr,
  output logic      [7:0] bus_wdata,
  input  wire logic [7:0] bus_rdata
);
  // Idle bus from time zero
  initial begin
    bus_rd      = 1'b0;
    bus_wr      = 1'b0;
    bus_space_b = 1'b0;
    bus_addr    = 6'h00;
    bus_wdata   = 8'h00;
  end

  // One-cycle write; address and data inverted after (space kept), so stale values never help the slave
  task automatic write(input logic sp, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr      <= 1'b1;
    bus_space_b <= sp;
    bus_addr    <= a;
    bus_wdata   <= d;
    @(posedge clk);
    bus_wr    <= 1'b0;
    bus_addr  <= ~a;
    bus_wdata <= ~d;
  endtask

  // One-cycle read; data taken in the single cycle where it stands
  task automatic read(input logic sp, input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_rd      <= 1'b1;
    bus_space_b <= sp;
    bus_addr    <= a;
    @(posedge clk);
    bus_rd   <= 1'b0;
    bus_addr <= ~a;
    #1;
    d = bus_rdata;
  endtask
endmodule
`default_nettype wire

/* File: rfs_status_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Self-checking bench of the status/config register bank
// ****************************************************************
module rfs_status_regs_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic rd, wr, spb, cdone, cfail, ext, orun, ostb;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, v;
  logic [3:0] ags = 4'h0, pgs = 4'h0, asq = 4'h0, psq = 4'h0, aagc = 4'h0, pagc = 4'h0;
  logic [3:0] step = 4'h0;
  logic [4:0] cval, in_use;
  logic [2:0] gcode;
  logic [1:0] lvl;
  logic [13:0] pat;
  logic cha = 0, txa = 0, txca = 0, rxe = 0, rxr = 0, peer = 0, ca = 0;
  logic auto_en, gvalid, apply, dr, am, stp;
  int bad_count = 0;
  int cmp_count = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  rfs_host_model i_host (.clk(clk), .bus_rd(rd), .bus_wr(wr), .bus_space_b(spb),
    .bus_addr(addr), .bus_wdata(wdata), .bus_rdata(rdata));

  rfs_status_regs i_dut (.clk(clk), .rst_b(rst_b), .bus_rd(rd), .bus_wr(wr),
    .bus_space_b(spb), .bus_addr(addr), .bus_wdata(wdata), .bus_rdata(rdata),
    .am_gain_cut_setting(ags), .pm_gain_cut_setting(pgs), .am_squelch_cut(asq),
    .pm_squelch_cut(psq), .am_agc_cut(aagc), .pm_agc_cut(pagc),
    .rx_channel_pm(cha), .tx_active(txa), .tx_ca_auto(txca), .rx_enabled(rxe),
    .rx_receiving(rxr), .efd_peer_mode(peer), .collision_avoid_armed(ca),
    .ext_field_pin(ext), .osc_running_pin(orun), .osc_stable_pin(ostb),
    .cal_done_pin(cdone), .cal_fail_pin(cfail), .cal_value_pin(cval),
    .cap_cal_in_use(in_use), .cap_auto_cal_en(auto_en), .cap_gain_code(gcode),
    .cap_gain_valid(gvalid), .overshoot_step(step), .overshoot_drive_level(lvl),
    .overshoot_bit_pattern(pat), .overshoot_apply(apply), .drive_from_dr(dr),
    .drive_from_am(am), .drive_stop(stp));

  initial begin
    {ext, orun, ostb, cdone, cfail, cval} = '0;
  end

  // Compare one value, count and report
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Read a register and compare
  task automatic rchk(input logic sp, input logic [5:0] a, input logic [7:0] exp);
    i_host.read(sp, a, v);
    chk(16'(v), 16'(exp));
  endtask

  // Let synchronised pins settle
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset state, read-data pulse
  task automatic t_reset();
    rchk(1'b0, rfs_pkg::OFF_CAP_CTRL, 8'h00);
    rchk(1'b1, rfs_pkg::OFF_OV_HIGH, 8'h00);
    rchk(1'b1, rfs_pkg::OFF_OV_LOW, 8'h00);
    @(posedge clk);
    #1;
    chk(16'(rdata), 16'h0000);
    chk(16'({auto_en, dr, am, stp}), 16'h000C);
  endtask

  // Manual calibration, gain codes, automatic calibration
  task automatic t_cap();
    i_host.write(1'b0, rfs_pkg::OFF_CAP_CTRL, 8'h1A);
    rchk(1'b0, rfs_pkg::OFF_CAP_CTRL, 8'h1A);
    settle();
    chk(16'({auto_en, in_use, gcode}), 16'h001A);
    rchk(1'b0, rfs_pkg::OFF_CAP_DISP, 8'h1C);
    for (int g = 0; g < 8; g++) begin
      i_host.write(1'b0, rfs_pkg::OFF_CAP_CTRL, {5'h10, 3'(g)});
      settle();
      chk(16'({gcode, gvalid}), 16'({3'(g), g inside {0, 1, 2, 4, 6}}));
    end
    rchk(1'b0, rfs_pkg::OFF_CAP_DISP, 8'h84);
    @(posedge clk);
    cdone <= 1'b1;
    cfail <= 1'b1;
    cval  <= 5'h15;
    i_host.write(1'b0, rfs_pkg::OFF_CAP_CTRL, 8'h00);
    settle();
    chk(16'({auto_en, in_use}), 16'h0035);
    rchk(1'b0, rfs_pkg::OFF_CAP_DISP, 8'hAE);
    i_host.write(1'b0, rfs_pkg::OFF_CAP_CTRL, 8'h1A);
    settle();
  endtask

  // Each auxiliary status bit alone, with its qualifying cases
  task automatic t_aux();
    logic [9:0] st [10] = '{10'h200, 10'h100, 10'h080, 10'h0C0, 10'h020,
                            10'h030, 10'h008, 10'h004, 10'h002, 10'h001};
    logic [7:0] ex [10] = '{8'h80, 8'h40, 8'h20, 8'h00, 8'h00,
                            8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      {cha, ext, txa, txca, orun, ostb, rxe, rxr, peer, ca} <= st[i];
      settle();
      rchk(1'b0, rfs_pkg::OFF_AUX, ex[i]);
    end
    @(posedge clk);
    {cha, ext, txa, txca, orun, ostb, rxe, rxr, peer, ca} <= '0;
  endtask

  // Gain totals, then writes to read-only places
  task automatic t_gain_ro();
    @(posedge clk);
    {ags, asq, aagc} <= {4'h2, 4'h3, 4'h4};
    {pgs, psq, pagc} <= {4'h8, 4'h8, 4'h1};
    settle();
    rchk(1'b0, rfs_pkg::OFF_GAIN_CUT, 8'h9F);
    i_host.write(1'b0, rfs_pkg::OFF_GAIN_CUT, 8'h00);
    i_host.write(1'b0, rfs_pkg::OFF_CAP_DISP, 8'hFF);
    i_host.write(1'b0, rfs_pkg::OFF_AUX, 8'hFF);
    i_host.write(1'b0, 6'h3F, 8'hFF);
    settle();
    rchk(1'b0, rfs_pkg::OFF_GAIN_CUT, 8'h9F);
    rchk(1'b0, rfs_pkg::OFF_CAP_DISP, 8'h1C);
    rchk(1'b0, rfs_pkg::OFF_AUX, 8'h00);
    rchk(1'b0, rfs_pkg::OFF_CAP_CTRL, 8'h1A);
    rchk(1'b0, 6'h3F, 8'h00);
    rchk(1'b1, rfs_pkg::OFF_OV_HIGH, 8'h00);
    rchk(1'b1, rfs_pkg::OFF_OV_LOW, 8'h00);
  endtask

  // Reset in mid-run clears the configuration written before it
  task automatic t_mid_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rchk(1'b0, rfs_pkg::OFF_CAP_CTRL, 8'h00);
    rchk(1'b1, rfs_pkg::OFF_OV_HIGH, 8'h00);
    rchk(1'b1, rfs_pkg::OFF_OV_LOW, 8'h00);
    chk(16'({auto_en, dr, am, stp}), 16'h000C);
  endtask

  // Drive levels and the split fourteen-bit pattern
  task automatic t_overshoot();
    logic [2:0] dec [4] = '{3'b100, 3'b010, 3'b001, 3'b000};
    logic [13:0] p = 14'b101010_01011010;
    i_host.write(1'b1, rfs_pkg::OFF_OV_LOW, 8'h5A);
    for (int m = 0; m < 4; m++) begin
      i_host.write(1'b1, rfs_pkg::OFF_OV_HIGH, {2'(m), 6'h2A});
      @(posedge clk);
      #1;
      chk(16'({lvl, dr, am, stp}), 16'({2'(m), dec[m]}));
    end
    chk(16'(pat), 16'(p));
    rchk(1'b1, rfs_pkg::OFF_OV_HIGH, 8'hEA);
    rchk(1'b1, rfs_pkg::OFF_OV_LOW, 8'h5A);
    for (int s = 0; s < 16; s++) begin
      @(posedge clk);
      step <= 4'(s);
      repeat (2) @(posedge clk);
      #1;
      chk(16'(apply), 16'((s < 14) ? p[s] : 1'b0));
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog, far above the expected few hundred cycles
  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_cap();
    t_aux();
    t_gain_ro();
    t_overshoot();
    t_mid_reset();
    summarize();
  end
endmodule
`default_nettype wire
